// ==== design/ssr_defines.svh ====
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// register width and bit positions
`define SSR_WIDTH 16
`define SSR_TOP_BIT 15
`define SSR_PRIOR_BIT 14

// reset values
`define SSR_SHIFT_RESET 16'h0000
`define SSR_STORE_RESET 16'h0000
`define SSR_CLEARED 16'h0000

// pin synchroniser depth (first flop, second flop, third flop)
`define SSR_SYNC_STAGES 3

// pin levels held during reset: select and store-clear idle high, the rest low
`define SSR_PIN_RESET_LEVEL 6'h11

`endif

// ==== design/ssr_pin_sync.sv ====
`include "ssr_defines.svh"

module ssr_pin_sync
#(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_LEVEL = '0
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // a change is taken only once the second and third flops agree
            assign agree[i] = ~(stage2_q[i] ^ stage3_q[i]);
            assign level_d[i] = agree[i] ? stage3_q[i] : level_q[i];
            assign rise[i] = level_d[i] & ~level_q[i];
            assign fall[i] = ~level_d[i] & level_q[i];
        end
    endgenerate

    assign level = level_q;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1_q <= RESET_LEVEL;
            stage2_q <= RESET_LEVEL;
            stage3_q <= RESET_LEVEL;
            level_q <= RESET_LEVEL;
        end
        else
        begin
            stage1_q <= raw;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            level_q <= level_d;
        end
    end
endmodule

// ==== design/ssr_pkg.sv ====
package ssr_pkg;

    // outside pins sampled by the block, bit order fixed by the packing
    typedef struct packed {
        logic serialIn;
        logic csN;
        logic readNotWrite;
        logic shiftClock;
        logic modeOrStoreClock;
        logic storeClearN;
    } ssr_pins_s;

    localparam int SSR_PIN_COUNT = $bits(ssr_pins_s);

endpackage

// ==== design/ssr_shift_storage.sv ====
// How it works
// RULE1: shift register and storage register, both sixteen bits wide.
// RULE2: one three-state serial pin both takes in and reads out shift data.
// RULE3: store-clear low forces the storage register to zero, no clock edge needed.
// RULE4: store-clear works even while the chip is deselected.
// RULE5: deselected chip ignores both clocks and floats the serial pin.
// RULE6: store-clock rise, selected, write, clear high: storage captures shift register.
// RULE7: shift-clock fall, selected, read, mode high: shift register reloads from storage.
// RULE8: after reload pin shows old storage top bit; under clear zeros load.
// RULE9: read mode shift-clock fall shifts; pin then drives old bit fourteen.
// RULE10: selected in read, the pin drives the shift register top bit.
// RULE11: write mode floats the pin and shifts in its level on each fall.
// RULE12: controller keeps shift clock low while releasing chip select.
// RULE13: controller keeps store clock low while asserting chip select.
// RULE14: each shift enters bit zero and moves every bit toward bit fifteen.
// RULE15: parallel outputs always mirror storage, whatever chip select does.
`include "ssr_defines.svh"

module ssr_shift_storage
#(
    parameter int WIDTH = `SSR_WIDTH
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic csN,
    input wire logic readNotWrite,
    input wire logic shiftClock,
    input wire logic modeOrStoreClock,
    input wire logic storeClearN,
    input wire logic serialIoIn,
    output logic serialIoOut,
    output logic serialIoOeN,
    output logic [WIDTH-1:0] storageOutputs
);
    import ssr_pkg::*;

    ssr_pins_s pinRaw;
    ssr_pins_s pinLvl;
    ssr_pins_s pinRise;
    ssr_pins_s pinFall;
    logic [WIDTH-1:0] shift_q; // see RULE1
    logic [WIDTH-1:0] shift_d;
    logic [WIDTH-1:0] storage_q; // see RULE1
    logic [WIDTH-1:0] storage_d;
    logic [WIDTH-1:0] shiftedIn;
    logic [WIDTH-1:0] reloadValue;
    logic selected;
    logic readMode;
    logic shiftFall;
    logic writeShift;
    logic readShift;
    logic reload;
    logic storeRise;
    logic clearActive;

    assign pinRaw.serialIn = serialIoIn;
    assign pinRaw.csN = csN;
    assign pinRaw.readNotWrite = readNotWrite;
    assign pinRaw.shiftClock = shiftClock;
    assign pinRaw.modeOrStoreClock = modeOrStoreClock;
    assign pinRaw.storeClearN = storeClearN;

    // every pin is asynchronous to clk, so all of them share one synchroniser
    ssr_pin_sync #(
        .WIDTH(SSR_PIN_COUNT),
        .RESET_LEVEL(SSR_PIN_COUNT'(`SSR_PIN_RESET_LEVEL))
    ) u_pin_sync (
        .clk(clk),
        .srst(srst),
        .raw(pinRaw),
        .level(pinLvl),
        .rise(pinRise),
        .fall(pinFall)
    );

    assign selected = ~pinLvl.csN; // see RULE5
    assign clearActive = ~pinLvl.storeClearN; // see RULE4
    assign readMode = selected & pinLvl.readNotWrite;
    assign shiftFall = selected & pinFall.shiftClock; // see RULE5
    assign writeShift = shiftFall & ~pinLvl.readNotWrite; // see RULE11
    assign readShift = shiftFall & pinLvl.readNotWrite & ~pinLvl.modeOrStoreClock; // see RULE9
    assign reload = shiftFall & pinLvl.readNotWrite & pinLvl.modeOrStoreClock; // see RULE7
    // the store clock is only honoured in write mode; a rise during read is mode, not store
    assign storeRise = selected & pinRise.modeOrStoreClock & ~pinLvl.readNotWrite
        & pinLvl.storeClearN; // see RULE6

    // bit zero takes the new bit; read mode recirculates the top bit so the word survives
    assign shiftedIn = {shift_q[WIDTH-2:0],
        (writeShift ? pinLvl.serialIn : shift_q[WIDTH-1])}; // see RULE14
    assign reloadValue = clearActive ? `SSR_CLEARED : storage_q; // see RULE8

    always_comb
    begin
        shift_d = shift_q;
        if (reload)
        begin
            shift_d = reloadValue; // see RULE7
        end
        else if (writeShift || readShift)
        begin
            shift_d = shiftedIn; // see RULE9
        end
    end

    // clear beats capture; it is a level so it holds storage empty while low
    assign storage_d = clearActive ? `SSR_CLEARED : (storeRise ? shift_q : storage_q); // see RULE3

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shift_q <= `SSR_SHIFT_RESET;
            storage_q <= `SSR_STORE_RESET;
        end
        else
        begin
            shift_q <= shift_d;
            storage_q <= storage_d;
        end
    end

    // pin is driven only in read mode; the output is the top flop itself
    assign serialIoOut = shift_q[WIDTH-1]; // see RULE10
    assign serialIoOeN = ~readMode; // see RULE2
    assign storageOutputs = storage_q; // see RULE15

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    chk_clear_empties: assert property (clearActive |=> storage_q == `SSR_CLEARED) // see RULE3
        else $error("storage not cleared after store-clear low");

    chk_clear_while_deselected: assert property ( // see RULE4
        (pinLvl.csN && clearActive) ##1 (pinLvl.csN && clearActive) |=>
            storageOutputs == `SSR_CLEARED && $stable(storageOutputs))
        else $error("store-clear masked by deselect");

    chk_deselect_holds: assert property ( // see RULE5
        pinLvl.csN && pinLvl.storeClearN |-> serialIoOeN ##1 $stable(shift_q))
        else $error("deselected chip drove pin or shifted");

    chk_store_capture: assert property ( // see RULE6
        storeRise |=> storageOutputs == $past(shift_q))
        else $error("storage did not capture shift register");

    chk_reload_value: assert property ( // see RULE7
        reload && !clearActive |=> shift_q == $past(storage_q)
            && serialIoOut == $past(storage_q[`SSR_TOP_BIT]))
        else $error("reload did not copy storage");

    chk_reload_cleared: assert property ( // see RULE8
        reload && clearActive |=> shift_q == `SSR_CLEARED && !serialIoOut)
        else $error("reload under clear did not load zeros");

    chk_read_shift: assert property ( // see RULE9
        readShift |=> serialIoOut == $past(shift_q[`SSR_PRIOR_BIT])
            && shift_q[0] == $past(shift_q[`SSR_TOP_BIT]))
        else $error("read shift did not present prior bit fourteen");

    chk_read_drive: assert property ( // see RULE10
        readMode |-> !serialIoOeN && serialIoOut == shift_q[`SSR_TOP_BIT])
        else $error("read mode pin not driving top bit");

    chk_write_shift: assert property ( // see RULE11
        writeShift |-> serialIoOeN ##1
            shift_q == {$past(shift_q[WIDTH-2:0]), $past(pinLvl.serialIn)})
        else $error("write shift wrong or pin driven");

    chk_outputs_follow: assert property ( // see RULE15
        !storeRise && !clearActive |=> $stable(storageOutputs))
        else $error("parallel outputs moved without store or clear");

    cov_store: cover property (writeShift ##[1:200] storeRise);
    cov_reload_read: cover property (reload ##[1:200] readShift);
    cov_clear_deselected: cover property (pinLvl.csN && clearActive);
    cov_reload_cleared: cover property (reload && clearActive);
endmodule

// ==== verif/ssr_ctrl_model.sv ====
module ssr_ctrl_model
(
    input wire logic clk,
    input wire logic serialIoOut,
    input wire logic serialIoOeN,
    output ssr_pkg::ssr_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssr_pkg::*;
    logic cs = 1'b1;
    logic rw = 1'b0;
    logic sck = 1'b0;
    logic msk = 1'b0;
    logic clr = 1'b1;
    logic dat = 1'b0;
    logic lastQ = 1'b0;
    logic pinLevel;
    // nobody driving: show a changing level so a float is never read as data
    // an unknown enable before reset counts as released, so lastQ never latches an unknown
    assign pinLevel = (serialIoOeN === 1'b0) ? serialIoOut : (!cs && !rw) ? dat : !lastQ;
    assign pins = {pinLevel, cs, rw, sck, msk, clr};
    always @(posedge clk) lastQ <= pinLevel;
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // clocks parked low across every select change
    task automatic select(input logic s);
        sck = 1'b0;
        msk = 1'b0;
        hold(5);
        cs = s;
        hold(5);
    endtask
    task automatic mode(input logic r, input logic m);
        rw = r;
        msk = m;
        hold(5);
    endtask
    task automatic pulse(input logic store);
        if (store) msk = 1'b1;
        else sck = 1'b1;
        hold(5);
        if (store) msk = 1'b0;
        else sck = 1'b0;
        hold(6);
    endtask
    task automatic send_bit(input logic b);
        dat = b;
        pulse(1'b0);
    endtask
    task automatic set_clear(input logic c);
        clr = c;
    endtask
endmodule

// ==== verif/tb_ssr_shift_storage.sv ====
module tb_ssr_shift_storage;
    timeunit 1ns;
    timeprecision 1ps;
    import ssr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    ssr_pins_s pins;
    logic sOut;
    logic oeN;
    logic [15:0] store;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic [15:0] word;
    // word written serially beside the storage value it must produce
    logic [31:0] rows [3] = '{32'hA5C3_A5C3, 32'h7FFE_7FFE, 32'h8001_8001};
    always #4 clk = ~clk;
    ssr_shift_storage uut
    (
        .clk(clk),
        .srst(srst),
        .csN(pins.csN),
        .readNotWrite(pins.readNotWrite),
        .shiftClock(pins.shiftClock),
        .modeOrStoreClock(pins.modeOrStoreClock),
        .storeClearN(pins.storeClearN),
        .serialIoIn(pins.serialIn),
        .serialIoOut(sOut),
        .serialIoOeN(oeN),
        .storageOutputs(store)
    );
    ssr_ctrl_model ctl
    (
        .clk(clk),
        .serialIoOut(sOut),
        .serialIoOeN(oeN),
        .pins(pins)
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        // control pins idle at the synchroniser's reset level, so two cycles suffice
        ctl.hold(2);
        srst = 1'b0;
        ctl.hold(1);
        check(store, 16'h0000);
        check(oeN, 1'b1);
        $display("reset test done");
        for (int r = 0; r < 3; r++)
        begin
            word = rows[r][31:16];
            ctl.select(1'b0);
            ctl.mode(1'b0, 1'b0);
            check(oeN, 1'b1);
            for (int i = 15; i >= 0; i--)
            begin
                ctl.send_bit(word[i]);
            end
            ctl.pulse(1'b1);
            check(store, rows[r][15:0]);
            // spoil the shift register so the reload has something to restore
            ctl.send_bit(~word[0]);
            check(store, rows[r][15:0]);
            ctl.mode(1'b1, 1'b0);
            ctl.mode(1'b1, 1'b1);
            ctl.pulse(1'b0);
            check(sOut, word[15]);
            check(oeN, 1'b0);
            ctl.mode(1'b1, 1'b0);
            for (int i = 14; i >= 0; i--)
            begin
                ctl.pulse(1'b0);
                check(sOut, word[i]);
            end
            $display("row %0d test done", r);
        end
        ctl.mode(1'b0, 1'b0);
        ctl.select(1'b1);
        check(oeN, 1'b1);
        repeat (2) ctl.pulse(1'b0);
        ctl.pulse(1'b1);
        check(store, 16'h8001);
        ctl.set_clear(1'b0);
        ctl.hold(6);
        check(store, 16'h0000);
        ctl.select(1'b0);
        ctl.mode(1'b1, 1'b1);
        check(sOut, 1'b1);
        ctl.pulse(1'b0);
        check(sOut, 1'b0);
        check(store, 16'h0000);
        $display("deselect and clear test done");
        print_verdict();
    end
endmodule
